// ### irs_bus_master.sv
// Two-wire bus master model for the slave bench
`default_nettype none
module irs_bus_master (
  // Bench clock
  input wire logic clk_i,
  // Bus lines
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // One bus clock of 80 ns; data moves only in the low phase
  task automatic bitx(input logic b, output logic r);
    hc(2);
    sda_low_o = !b;
    hc(3);
    scl_o = 1'b1;
    hc(2);
    r = sda_i;
    hc(3);
    scl_o = 1'b0;
  endtask
  task automatic start();
    hc(2);
    sda_low_o = 1'b0;
    hc(3);
    scl_o = 1'b1;
    hc(3);
    sda_low_o = 1'b1;
    hc(5);
    scl_o = 1'b0;
  endtask
  // Leaves the clock standing high
  task automatic stop();
    hc(2);
    sda_low_o = 1'b1;
    hc(3);
    scl_o = 1'b1;
    hc(3);
    sda_low_o = 1'b0;
    hc(5);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(!ack, r);
  endtask
endmodule
`default_nettype wire

// ### irs_slave.sv
// Two-wire register access slave: constants package and slave logic
`default_nettype none

package irs_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [3:0] ADDR_UPPER = 4'hb;
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_OPEN = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  localparam logic [3:0] SEL_LEVELS = 4'h3;
  localparam logic [3:0] SEL_CODE_OFF = 4'h8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] IDX_HIGH = 2'h0;
  localparam logic [1:0] IDX_LOW = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam logic [ADDR_W-1:0] PTR_RESET = 16'h0000;
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_RX, ST_TX} irs_state_t;
endpackage

// Behaviour
// - Data line changes only while clock is low; stays stable while clock high.
// - Data falling while clock high is a start; begins address reception.
// - Data rising while clock high is a stop; ends the transfer.
// - Bytes are eight bits, MSB first, followed by an acknowledge slot.
// - Receiver acknowledges by pulling data low on the ninth clock pulse.
// - Released data line on the ninth pulse means refused or final byte.
// - Address byte is 7-bit address then direction bit, 0 write, 1 read.
// - Acknowledge only own address; otherwise stay idle until next start.
// - Address is 1011 plus select-pin code; one pin combination disables port.
// - First two write bytes load the 16-bit register pointer, high first.
// - Any number of following write bytes are stored from the pointer onward.
// - Read returns bytes from the pointer while the master acknowledges.
// - Master non-acknowledge ends a read; device releases the data line.
// - Repeated start accepted; start or stop anywhere discards partial byte.
// - Address-only write followed by stop just sets the pointer.
// - Combined format: pointer write, repeated start, then read from pointer.
// - Slave only, never drives the clock; standard and fast rates both work.
module irs_slave (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Three-level address select straps
  input wire logic [1:0] port_select_upper_pin_i,
  input wire logic [1:0] port_select_lower_pin_i,
  // Control register access
  output logic [irs_pkg::ADDR_W-1:0] reg_addr_o,
  output logic [irs_pkg::DATA_W-1:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [irs_pkg::DATA_W-1:0] reg_rdata_i,
  // Status
  output logic port_off_o
);

  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  logic [1:0] selu_m_r, selu_s_r, sell_m_r, sell_s_r;
  irs_pkg::irs_state_t st_r;
  logic [3:0] bitcnt_r;
  logic in_ack_r, rw_r, nack_r;
  logic [1:0] byte_idx_r;
  logic [irs_pkg::DATA_W-1:0] shift_r, tx_byte_r;
  logic [irs_pkg::ADDR_W-1:0] ptr_r;

  // Clock is only sampled, never driven
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
      {selu_m_r, selu_s_r, sell_m_r, sell_s_r} <= 8'h00;
    end else begin
      {scl_m_r, scl_s_r, scl_d_r} <= {scl_i, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
      {selu_m_r, selu_s_r} <= {port_select_upper_pin_i, selu_m_r};
      {sell_m_r, sell_s_r} <= {port_select_lower_pin_i, sell_m_r};
    end
  end

  wire scl_rise = scl_s_r & ~scl_d_r;
  wire scl_fall = ~scl_s_r & scl_d_r;
  wire start_evt = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire stop_evt = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  wire [3:0] sel_code = {2'h0, selu_s_r} * irs_pkg::SEL_LEVELS + {2'h0, sell_s_r};
  wire port_off = (sel_code == irs_pkg::SEL_CODE_OFF);
  wire [6:0] own_addr = {irs_pkg::ADDR_UPPER, sel_code[2:0]};
  wire addr_match = (shift_r[7:1] == own_addr) & ~port_off;
  wire byte_end = scl_fall & ~in_ack_r & (bitcnt_r == irs_pkg::BYTE_BITS);
  wire ack_end = scl_fall & in_ack_r;
  wire [1:0] idx_nxt = (byte_idx_r == irs_pkg::IDX_DATA) ? byte_idx_r : byte_idx_r + 2'h1;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_off_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      port_off_o <= port_off;
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= irs_pkg::ST_IDLE;
      bitcnt_r <= 4'h0;
      in_ack_r <= 1'b0;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      byte_idx_r <= irs_pkg::IDX_HIGH;
      shift_r <= 8'h00;
      tx_byte_r <= 8'h00;
      ptr_r <= irs_pkg::PTR_RESET;
      sda_oe_n_o <= 1'b1;
      reg_addr_o <= irs_pkg::PTR_RESET;
      reg_wdata_o <= 8'h00;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
    end else begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      // Read data is valid while the read strobe is high
      if (reg_rd_o) begin
        tx_byte_r <= reg_rdata_i;
      end
      if (start_evt) begin
        st_r <= irs_pkg::ST_ADDR;
        bitcnt_r <= 4'h0;
        in_ack_r <= 1'b0;
        byte_idx_r <= irs_pkg::IDX_HIGH;
        sda_oe_n_o <= 1'b1;
      end else if (stop_evt) begin
        st_r <= irs_pkg::ST_IDLE;
        in_ack_r <= 1'b0;
        sda_oe_n_o <= 1'b1;
      end else if (st_r != irs_pkg::ST_IDLE) begin
        if (scl_rise && !in_ack_r) begin
          shift_r <= {shift_r[6:0], sda_s_r};
          bitcnt_r <= bitcnt_r + 4'h1;
        end
        if (scl_rise && in_ack_r) begin
          nack_r <= sda_s_r;
        end
        if (byte_end) begin
          case (st_r)
            irs_pkg::ST_ADDR: begin
              if (addr_match) begin
                in_ack_r <= 1'b1;
                sda_oe_n_o <= 1'b0;
                rw_r <= shift_r[0];
                if (shift_r[0]) begin
                  reg_rd_o <= 1'b1;
                  reg_addr_o <= ptr_r;
                end
              end else begin
                st_r <= irs_pkg::ST_IDLE;
              end
            end
            irs_pkg::ST_RX: begin
              in_ack_r <= 1'b1;
              sda_oe_n_o <= 1'b0;
              byte_idx_r <= idx_nxt;
              case (byte_idx_r)
                irs_pkg::IDX_HIGH: ptr_r[15:8] <= shift_r;
                irs_pkg::IDX_LOW: ptr_r[7:0] <= shift_r;
                default: begin
                  reg_wr_o <= 1'b1;
                  reg_addr_o <= ptr_r;
                  reg_wdata_o <= shift_r;
                  ptr_r <= ptr_r + 16'h0001;
                end
              endcase
            end
            irs_pkg::ST_TX: begin
              in_ack_r <= 1'b1;
              sda_oe_n_o <= 1'b1;
              reg_rd_o <= 1'b1;
              reg_addr_o <= ptr_r;
            end
            default: st_r <= irs_pkg::ST_IDLE;
          endcase
        end else if (ack_end) begin
          in_ack_r <= 1'b0;
          bitcnt_r <= 4'h0;
          case (st_r)
            irs_pkg::ST_ADDR: begin
              if (rw_r) begin
                st_r <= irs_pkg::ST_TX;
                sda_oe_n_o <= tx_byte_r[7];
                ptr_r <= ptr_r + 16'h0001;
              end else begin
                st_r <= irs_pkg::ST_RX;
                sda_oe_n_o <= 1'b1;
              end
            end
            irs_pkg::ST_RX: sda_oe_n_o <= 1'b1;
            irs_pkg::ST_TX: begin
              if (nack_r) begin
                st_r <= irs_pkg::ST_IDLE;
                sda_oe_n_o <= 1'b1;
              end else begin
                sda_oe_n_o <= tx_byte_r[7];
                ptr_r <= ptr_r + 16'h0001;
              end
            end
            default: st_r <= irs_pkg::ST_IDLE;
          endcase
        end else if (scl_fall && st_r == irs_pkg::ST_TX && !in_ack_r) begin
          sda_oe_n_o <= tx_byte_r[~bitcnt_r[2:0]];
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_addr_done;
    byte_end && st_r == irs_pkg::ST_ADDR;
  endsequence

  sequence s_tx_nacked;
    ack_end && st_r == irs_pkg::ST_TX && nack_r;
  endsequence

  a_addr_ack_match: assert property (s_addr_done |=> sda_oe_n_o == !$past(addr_match))
    else $error("address acknowledge does not follow address match");
  a_start_to_addr: assert property (start_evt |=> st_r == irs_pkg::ST_ADDR && bitcnt_r == 4'h0 && sda_oe_n_o)
    else $error("start condition did not restart address reception");
  a_stop_release: assert property (stop_evt |=> st_r == irs_pkg::ST_IDLE && sda_oe_n_o)
    else $error("stop condition did not idle and release the bus");
  a_sda_change_low: assert property ($changed(sda_oe_n_o) && !$past(start_evt) && !$past(stop_evt)
    |-> !$past(scl_s_r))
    else $error("data line changed while clock high");
  a_write_advances: assert property (reg_wr_o |-> ptr_r == reg_addr_o + 16'h0001)
    else $error("pointer did not advance after write");
  a_nack_release: assert property (s_tx_nacked |=> st_r == irs_pkg::ST_IDLE ##0 sda_oe_n_o [*2])
    else $error("data line not released after master no acknowledge");
  a_port_off_quiet: assert property (s_addr_done ##0 port_off |=> sda_oe_n_o && st_r == irs_pkg::ST_IDLE)
    else $error("disabled port acknowledged an address");
  a_read_from_ptr: assert property (s_addr_done ##0 addr_match && shift_r[0]
    |=> reg_rd_o && reg_addr_o == $past(ptr_r))
    else $error("read did not start at the register pointer");
  a_rx_ack_low: assert property (in_ack_r && st_r == irs_pkg::ST_RX |-> !sda_oe_n_o)
    else $error("received byte not acknowledged");
  a_bit_count: assert property (bitcnt_r <= irs_pkg::BYTE_BITS)
    else $error("bit count beyond one byte");
  a_header_loads_ptr: assert property (byte_end && st_r == irs_pkg::ST_RX && byte_idx_r == irs_pkg::IDX_LOW
    |=> ptr_r[7:0] == $past(shift_r) && !reg_wr_o)
    else $error("low pointer byte not loaded");

endmodule

`default_nettype wire

// ### tb_i2c_register_access_slave.sv
// Self-checking bench for the two-wire register access slave
`default_nettype none
module tb_i2c_register_access_slave;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic scl, m_low, sda_o, sda_oe_n_o, reg_wr_o, reg_rd_o, port_off_o, a;
  logic [1:0] up = 2'h0;
  logic [1:0] lo = 2'h0;
  logic [15:0] reg_addr_o;
  logic [7:0] reg_wdata_o, d;
  logic [7:0] mem [256];
  int miscompares = 0;
  int n_checks = 0;
  int n_wr = 0;
  int n_rd = 0;
  integer seed = 32'hc5070c87;
  // Open-drain data line with pull-up
  wire logic sda = !(m_low || (!sda_oe_n_o && !sda_o));
  always #4 ref_clk_i = !ref_clk_i;
  irs_slave dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .port_select_upper_pin_i(up), .port_select_lower_pin_i(lo),
    .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
    .reg_rdata_i(mem[reg_addr_o[7:0]]), .port_off_o(port_off_o));
  irs_bus_master m (.clk_i(ref_clk_i), .scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
  // Register store behind the strobes
  always @(posedge ref_clk_i) begin
    if (reg_wr_o === 1'b1) begin
      mem[reg_addr_o[7:0]] <= reg_wdata_o;
      n_wr <= n_wr + 1;
    end
    if (reg_rd_o === 1'b1) begin
      n_rd <= n_rd + 1;
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (exp !== got) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [6:0] own(input logic [1:0] u, input logic [1:0] l);
    return {irs_pkg::ADDR_UPPER, 3'(u * 3 + l)};
  endfunction
  task automatic addr_phase(input logic [6:0] sa, input logic rw, input logic exp_ack);
    m.start();
    m.tx({sa, rw}, a);
    chk("address ack", exp_ack, a);
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    miscompares++;
    end_sim();
  end
  initial begin
    logic [15:0] p;
    logic [7:0] wb [4];
    logic [6:0] sa;
    int n, w, r;
    foreach (mem[i]) mem[i] = 8'($random(seed));
    repeat (10) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    chk("idle release", 1, sda_oe_n_o);
    for (int k = 0; k < 9; k++) begin
      up = 2'(k / 3);
      lo = 2'(k % 3);
      repeat (6) @(negedge ref_clk_i);
      chk("port off", k == 8, port_off_o);
      addr_phase(own(up, lo), 1'b0, k != 8);
      m.stop();
      addr_phase(own(up, lo) ^ 7'h40, 1'b0, 1'b0);
      m.stop();
    end
    n = $unsigned($random(seed)) % 8;
    up = 2'(n / 3);
    lo = 2'(n % 3);
    sa = own(up, lo);
    repeat (6) @(negedge ref_clk_i);
    for (int t = 0; t < 4; t++) begin
      p = (t == 0) ? 16'h00fe : 16'($random(seed));
      n = 1 + $unsigned($random(seed)) % 4;
      addr_phase(sa, 1'b0, 1'b1);
      m.tx(p[15:8], a);
      m.tx(p[7:0], a);
      for (int i = 0; i < n; i++) begin
        wb[i] = 8'($random(seed));
        m.tx(wb[i], a);
        chk("data ack", 1, a);
      end
      m.stop();
      for (int i = 0; i < n; i++) chk("stored byte", wb[i], mem[8'(p + i)]);
      // Plain read carries on from the advanced pointer
      addr_phase(sa, 1'b1, 1'b1);
      m.rx(1'b0, d);
      m.stop();
      chk("next byte", mem[8'(p + n)], d);
      // Pointer-only write closed by a stop, then a plain read from it
      w = n_wr;
      addr_phase(sa, 1'b0, 1'b1);
      m.tx(p[15:8], a);
      m.tx(p[7:0], a);
      m.stop();
      addr_phase(sa, 1'b1, 1'b1);
      m.rx(1'b0, d);
      m.stop();
      chk("pointer only read", mem[8'(p)], d);
      // Pointer-only write, a cut byte, then a combined read
      addr_phase(sa, 1'b0, 1'b1);
      m.tx(p[15:8], a);
      m.tx(p[7:0], a);
      repeat (3) m.bitx(1'b0, a);
      r = n_rd;
      addr_phase(sa, 1'b1, 1'b1);
      for (int i = 0; i < n; i++) begin
        m.rx(i < n - 1, d);
        chk("read byte", mem[8'(p + i)], d);
      end
      repeat (5) @(negedge ref_clk_i);
      chk("released after nack", 1, sda_oe_n_o);
      m.stop();
      // One fetch at the address byte and one as each byte ends, the refused one included
      chk("fetch count", 16'(r + n + 1), 16'(n_rd));
      chk("write count", 16'(w), 16'(n_wr));
    end
    // Mid-run reset returns the pointer to its reset value
    sys_rst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk("released in reset", 1, sda_oe_n_o);
    sys_rst_i = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    addr_phase(sa, 1'b1, 1'b1);
    m.rx(1'b0, d);
    m.stop();
    chk("read after reset", mem[8'(irs_pkg::PTR_RESET)], d);
    end_sim();
  end
endmodule
`default_nettype wire
